/* lpm_mode_ctrl.sv */
// Mode controller of a white-LED charge pump with APB status access.
// Assumes enable pins and analog detector levels are asynchronous.
// Notes on behaviour
// - Three pump states: off, x1.0, x1.5
// - Only internal logic picks x1.0 or x1.5
// - First enable rising edge leaves power-save
// - Enable high at power-up waits for POR
// - Startup runs x1.5 to detect LEDs
// - Chip-enable rises with first enable edge
// - Soft start from first edge, pulses accepted
// - LED current enabled just before soft end
// - Chip-enable follows OR of both enables
// - Both enables low for hold enters power-save
// - Power-save switches all LED drive off
// - Chip-enable fall resets mode; host resends setting
// - Stay x1.0 while currents are sufficient
// - Low current in x1.0 switches to x1.5
// - Any one channel can trigger boost
// - Periodic mode reset returns to x1.0
// - Mode hold window ignores low current
// - After hold window, act on detector
// - LED change after startup flags error
// - Unregulated channel never triggers boost
// - Power-save clears enable pulse counters
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "lpm_params.svh"
module lpm_mode_ctrl
    import lpm_pkg::*;
#(
    parameter int unsigned SOFT_START_CYCLES = `LPM_SOFT_CYCLES,
    parameter int unsigned HOLD_CYCLES       = `LPM_HOLD_CYCLES,
    parameter int unsigned MODE_RESET_CYCLES = `LPM_MODE_RESET_CYCLES
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      group_a_enable,
    input  wire logic                      group_b_enable,
    input  wire logic [`LPM_CHANNELS-1:0]  low_current,
    input  wire logic [`LPM_CHANNELS-1:0]  led_present,
    output logic                           pump_on,
    output logic                           pump_boost,
    output logic                           chip_enable,
    output logic                           led_current_on,
    output logic                           group_a_drive,
    output logic                           group_b_drive,
    output logic [3:0]                     group_a_step,
    output logic [3:0]                     group_b_step,
    output logic                           conn_error
);
    localparam int unsigned POR_CYCLES   = `LPM_POR_CYCLES;
    localparam int unsigned MHOLD_CYCLES = `LPM_MODE_HOLD_CYCLES;
    localparam int unsigned BOOST_CYCLES = `LPM_START_BOOST_CYC;
    localparam int unsigned LEAD_CYCLES  = `LPM_LED_LEAD_CYC;

    typedef struct packed {
        lpm_state_type              state;
        lpm_pump_type               pump;
        logic [11:0]                por_cnt;
        logic [31:0]                phase_cnt;
        logic [31:0]                off_cnt;
        logic [11:0]                hold_cnt;
        logic [31:0]                period_cnt;
        logic                       ce;
        logic                       led_on;
        logic                       en_prev;
        logic [`LPM_CHANNELS-1:0]   conn_map;
        logic                       conn_err;
        logic [15:0]                up_count;
        logic [31:0]                rdata;
    } lpm_core_type;

    lpm_core_type r;
    lpm_core_type next_r;

    logic [1:0]               en_sync;
    logic [`LPM_CHANNELS-1:0] low_sync;
    logic [`LPM_CHANNELS-1:0] present_sync;
    logic                     en_or;
    logic                     en_rise;
    logic                     por_exit;
    logic                     save_entry;
    logic [`LPM_GROUPS-1:0]   drive_vec;
    logic [3:0]               step_vec [`LPM_GROUPS];
    logic                     wr_ctrl;
    logic                     addr_ok;

    // Pins and detector levels cross in before any logic reads them
    lpm_sync #(.WIDTH(2)) u_en_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({group_b_enable, group_a_enable}),
        .sync_out (en_sync)
    );

    lpm_sync #(.WIDTH(2*`LPM_CHANNELS)) u_det_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({led_present, low_current}),
        .sync_out ({present_sync, low_sync})
    );

    assign en_or   = en_sync[0] | en_sync[1];
    assign en_rise = en_or & ~r.en_prev;

    generate
        for (genvar g = 0; g < `LPM_GROUPS; g++) begin : g_group
            lpm_step_counter u_step (
                .pclk      (pclk),
                .presetn   (presetn),
                .enable_in (en_sync[g]),
                .arm       ((r.state != LPM_POR) || por_exit),
                .kick      (por_exit),
                .clear     (save_entry),
                .led_on    (r.led_on),
                .step      (step_vec[g]),
                .drive     (drive_vec[g])
            );
        end
    endgenerate

    assign addr_ok = (paddr == `LPM_ADDR_STATUS) ||
                     (paddr == `LPM_ADDR_CTRL) ||
                     (paddr == `LPM_ADDR_UPCOUNT);
    assign wr_ctrl = psel && penable && pwrite &&
                     (paddr == `LPM_ADDR_CTRL);

    always_comb begin
        next_r     = r;
        por_exit   = 1'b0;
        save_entry = 1'b0;
        next_r.en_prev = en_or;

        // Software clears the error; a new mismatch in the same cycle wins
        if (wr_ctrl && pwdata[`LPM_CTRL_ERR_CLR]) begin
            next_r.conn_err = 1'b0;
        end

        unique case (r.state)
            LPM_POR: begin
                next_r.pump   = LPM_PUMP_OFF;
                next_r.led_on = 1'b0;
                next_r.por_cnt = r.por_cnt + 12'h001;
                if (32'(r.por_cnt) == POR_CYCLES - 1) begin
                    por_exit = 1'b1;
                    if (en_or) begin
                        // Enable already high: start only now
                        next_r.state     = LPM_SOFT;
                        next_r.ce        = 1'b1;
                        next_r.pump      = LPM_PUMP_X15;
                        next_r.phase_cnt = 32'h0000_0000;
                    end else begin
                        next_r.state = LPM_SAVE;
                    end
                end
            end
            LPM_SAVE: begin
                next_r.pump   = LPM_PUMP_OFF;
                next_r.led_on = 1'b0;
                next_r.ce     = en_or;
                if (en_rise) begin
                    next_r.state     = LPM_SOFT;
                    next_r.pump      = LPM_PUMP_X15;
                    next_r.phase_cnt = 32'h0000_0000;
                    next_r.off_cnt   = 32'h0000_0000;
                end
            end
            LPM_SOFT: begin
                next_r.ce        = en_or;
                next_r.phase_cnt = r.phase_cnt + 32'h0000_0001;
                // Fixed boost interval lets the connection detector settle
                if (r.phase_cnt == BOOST_CYCLES - 1) begin
                    next_r.pump     = LPM_PUMP_X10;
                    next_r.conn_map = present_sync;
                end
                if (r.phase_cnt >= SOFT_START_CYCLES - LEAD_CYCLES) begin
                    next_r.led_on = 1'b1;
                end
                if (r.phase_cnt == SOFT_START_CYCLES - 1) begin
                    next_r.state      = LPM_RUN;
                    next_r.pump       = LPM_PUMP_X10;
                    next_r.hold_cnt   = 12'h000;
                    next_r.period_cnt = 32'h0000_0000;
                end
            end
            LPM_RUN: begin
                next_r.ce         = en_or;
                next_r.period_cnt = r.period_cnt + 32'h0000_0001;
                if (r.ce && !en_or) begin
                    // Falling chip-enable drops mode state to a clean x1.0
                    next_r.pump     = LPM_PUMP_X10;
                    next_r.hold_cnt = 12'h000;
                end else if (r.period_cnt == MODE_RESET_CYCLES - 1) begin
                    next_r.period_cnt = 32'h0000_0000;
                    next_r.pump       = LPM_PUMP_X10;
                    next_r.hold_cnt   = 12'h000;
                end else if (r.pump == LPM_PUMP_X10) begin
                    if (32'(r.hold_cnt) != MHOLD_CYCLES) begin
                        next_r.hold_cnt = r.hold_cnt + 12'h001;
                    end else if (|(low_sync & r.conn_map)) begin
                        // Masked channels never boost
                        next_r.pump     = LPM_PUMP_X15;
                        next_r.up_count = r.up_count + 16'h0001;
                    end
                end
                if (present_sync != r.conn_map) begin
                    next_r.conn_err = 1'b1;
                end
            end
        endcase

        // Power-save after both enables stay low for the hold time
        if ((r.state == LPM_SOFT) || (r.state == LPM_RUN)) begin
            if (en_or) begin
                next_r.off_cnt = 32'h0000_0000;
            end else if (r.off_cnt == HOLD_CYCLES - 1) begin
                next_r.state   = LPM_SAVE;
                next_r.pump    = LPM_PUMP_OFF;
                next_r.led_on  = 1'b0;
                next_r.off_cnt = 32'h0000_0000;
                save_entry     = 1'b1;
            end else begin
                next_r.off_cnt = r.off_cnt + 32'h0000_0001;
            end
        end

        // Read data is captured in the setup phase for a zero-wait access
        if (psel && !penable && !pwrite) begin
            next_r.rdata = 32'h0000_0000;
            unique case (paddr)
                `LPM_ADDR_STATUS: begin
                    next_r.rdata[`LPM_ST_PUMP_LSB +: 2]  = r.pump;
                    next_r.rdata[`LPM_ST_STATE_LSB +: 2] = r.state;
                    next_r.rdata[`LPM_ST_CE]             = r.ce;
                    next_r.rdata[`LPM_ST_LED_ON]         = r.led_on;
                    next_r.rdata[`LPM_ST_CONN_ERR]       = r.conn_err;
                    next_r.rdata[`LPM_ST_STEP_A_LSB +: 4] = step_vec[0];
                    next_r.rdata[`LPM_ST_STEP_B_LSB +: 4] = step_vec[1];
                    next_r.rdata[`LPM_ST_CONN_MAP_LSB +: `LPM_CHANNELS] =
                        r.conn_map;
                end
                `LPM_ADDR_UPCOUNT: begin
                    next_r.rdata[15:0] = r.up_count;
                end
                default: begin
                    next_r.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r       <= '0;
            r.state <= LPM_POR;
            r.pump  <= LPM_PUMP_OFF;
        end else begin
            r <= next_r;
        end
    end

    // Pump mode has no software path: the control register only clears
    assign pump_on        = (r.pump != LPM_PUMP_OFF);
    assign pump_boost     = (r.pump == LPM_PUMP_X15);
    assign chip_enable    = r.ce;
    assign led_current_on = r.led_on;
    assign group_a_drive  = drive_vec[0];
    assign group_b_drive  = drive_vec[1];
    assign group_a_step   = step_vec[0];
    assign group_b_step   = step_vec[1];
    assign conn_error     = r.conn_err;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = r.rdata;
endmodule

/* lpm_params.svh */
// Constants of the LED pump mode controller: offsets, fields, timings.
// Assumes a 40 MHz pclk; every count is derived from a time in ns.
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

`define LPM_CLK_PERIOD_NS     25
`define LPM_POR_TIME_NS       50000
`define LPM_SOFT_TIME_NS      1300000
`define LPM_HOLD_MAX_NS       1630000
`define LPM_MODE_RESET_NS     1400000000
`define LPM_MODE_HOLD_MIN_NS  85000
`define LPM_START_BOOST_NS    100000
`define LPM_LED_LEAD_NS       10000

// Least times round up, longest times round down
`define LPM_CEIL_CYC(t)  (((t) + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
`define LPM_FLOOR_CYC(t) ((t) / `LPM_CLK_PERIOD_NS)

`define LPM_POR_CYCLES        `LPM_CEIL_CYC(`LPM_POR_TIME_NS)
`define LPM_SOFT_CYCLES       `LPM_CEIL_CYC(`LPM_SOFT_TIME_NS)
`define LPM_HOLD_CYCLES       `LPM_FLOOR_CYC(`LPM_HOLD_MAX_NS)
`define LPM_MODE_RESET_CYCLES `LPM_FLOOR_CYC(`LPM_MODE_RESET_NS)
`define LPM_MODE_HOLD_CYCLES  `LPM_CEIL_CYC(`LPM_MODE_HOLD_MIN_NS)
`define LPM_START_BOOST_CYC   `LPM_CEIL_CYC(`LPM_START_BOOST_NS)
`define LPM_LED_LEAD_CYC      `LPM_FLOOR_CYC(`LPM_LED_LEAD_NS)

`define LPM_ADDR_STATUS       12'h000
`define LPM_ADDR_CTRL         12'h004
`define LPM_ADDR_UPCOUNT      12'h008

`define LPM_CTRL_ERR_CLR      0
`define LPM_ST_PUMP_LSB       0
`define LPM_ST_STATE_LSB      2
`define LPM_ST_CE             4
`define LPM_ST_LED_ON         5
`define LPM_ST_CONN_ERR       6
`define LPM_ST_STEP_A_LSB     8
`define LPM_ST_STEP_B_LSB     12
`define LPM_ST_CONN_MAP_LSB   16

`define LPM_CHANNELS          6
`define LPM_GROUPS            2

`endif

/* lpm_pkg.sv */
// Types shared by the LED pump mode controller modules.
// Assumes lpm_params.svh for widths of the channel vectors.
package lpm_pkg;

    typedef enum logic [1:0] {
        LPM_POR,
        LPM_SAVE,
        LPM_SOFT,
        LPM_RUN
    } lpm_state_type;

    typedef enum logic [1:0] {
        LPM_PUMP_OFF,
        LPM_PUMP_X10,
        LPM_PUMP_X15
    } lpm_pump_type;

endpackage

/* lpm_sync.sv */
// Two-flop synchroniser for asynchronous levels.
// Assumes inputs may change at any time relative to pclk.
`timescale 1ns/10ps
module lpm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } lpm_sync_type;

    lpm_sync_type r;
    lpm_sync_type next_r;

    // The first stage feeds only the second stage
    always_comb begin
        next_r.first  = async_in;
        next_r.second = r.first;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.second;
endmodule

/* lpm_step_counter.sv */
// Enable pulse counter of one LED group: 16 current steps.
// Assumes a synchronised enable level and a one-cycle clear.
`timescale 1ns/10ps
module lpm_step_counter (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       enable_in,
    input  wire logic       arm,
    input  wire logic       kick,
    input  wire logic       clear,
    input  wire logic       led_on,
    output logic [3:0]      step,
    output logic            drive
);
    typedef struct packed {
        logic [3:0] count;
        logic       seen;
        logic       prev;
    } lpm_step_type;

    lpm_step_type r;
    lpm_step_type next_r;

    always_comb begin
        next_r      = r;
        next_r.prev = enable_in;
        if (clear) begin
            next_r.count = 4'h0;
            next_r.seen  = 1'b0;
        end else if (arm && enable_in && (!r.prev || kick)) begin
            // Wraps from 16 back to 1 on the 17th pulse
            next_r.count = r.count + 4'h1;
            next_r.seen  = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Count value 0 after a pulse stands for step 16, drive off
    assign step  = r.count;
    assign drive = led_on && enable_in && r.seen && (r.count != 4'h0);
endmodule

/* lpm_chk.sv */
// Checker of the LED pump mode controller, bound to its top ports.
// Assumes one pclk domain and the top's count parameters.
`timescale 1ns/10ps
`include "lpm_params.svh"
module lpm_chk #(
    parameter int unsigned SOFT_START_CYCLES = 6000,
    parameter int unsigned HOLD_CYCLES       = 100,
    parameter int unsigned MODE_RESET_CYCLES = 8000
) (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     group_a_enable,
    input wire logic                     group_b_enable,
    input wire logic [`LPM_CHANNELS-1:0] low_current,
    input wire logic [`LPM_CHANNELS-1:0] led_present,
    input wire logic                     pump_on,
    input wire logic                     pump_boost,
    input wire logic                     chip_enable,
    input wire logic                     led_current_on,
    input wire logic                     group_a_drive,
    input wire logic                     group_b_drive,
    input wire logic [3:0]               group_a_step,
    input wire logic [3:0]               group_b_step,
    input wire logic                     conn_error
);
    // Shortest mode hold, 85 us at 40 MHz
    localparam int HOLD_MIN = 3400;
    logic [31:0] on_cnt, x1_cnt, b_cnt, lo_cnt, st_cnt;
    logic        en_or, starved, x1;
    assign en_or   = group_a_enable | group_b_enable;
    assign starved = |(low_current & led_present);
    assign x1      = pump_on && !pump_boost;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_cnt <= '0;
            x1_cnt <= '0;
            b_cnt  <= '0;
            lo_cnt <= '0;
            st_cnt <= '0;
        end else begin
            on_cnt <= pump_on ? on_cnt + 1 : '0;
            // A chip-enable fall restarts the mode hold in the design
            x1_cnt <= (x1 && !$fell(chip_enable)) ? x1_cnt + 1 : '0;
            // Long starving stretch counted here, too long for a range
            st_cnt <= (x1 && chip_enable && starved && !conn_error) ?
                      st_cnt + 1 : '0;
            b_cnt  <= pump_boost ? b_cnt + 1 : '0;
            lo_cnt <= en_or ? '0 : lo_cnt + 1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_starving;
        (x1 && starved && !conn_error) [*4];
    endsequence
    sequence s_fed;
        (x1 && !starved && !conn_error) [*4];
    endsequence
    a_boost_in_pump: assert property (pump_boost |-> pump_on)
        else $error("boost with pump off");
    a_start_boost: assert property (
        $rose(pump_on) |-> pump_boost && chip_enable)
        else $error("startup not in boost");
    a_off_quiet: assert property (
        !pump_on |-> !chip_enable && !led_current_on
                     && !group_a_drive && !group_b_drive)
        else $error("drive while pump off");
    a_led_late: assert property (
        $rose(led_current_on) |-> on_cnt + 402 >= SOFT_START_CYCLES
                                  && on_cnt + 398 <= SOFT_START_CYCLES)
        else $error("led current at wrong time");
    a_drive_needs_led: assert property (
        group_a_drive || group_b_drive |-> led_current_on)
        else $error("drive before led current");
    a_ce_low: assert property ((!en_or) [*5] |-> !chip_enable)
        else $error("chip enable ignores pins");
    a_save_on_hold: assert property (
        lo_cnt > HOLD_CYCLES + 4 |-> !pump_on && group_a_step == 4'h0
                                     && group_b_step == 4'h0)
        else $error("no power-save after hold");
    a_hold_window: assert property (
        $rose(pump_boost) && $past(pump_on) |-> $past(x1_cnt) >= HOLD_MIN - 1)
        else $error("boost inside mode hold");
    a_boost_in_time: assert property (
        s_starving |-> st_cnt <= 7504)
        else $error("low current not acted on");
    a_no_stray_boost: assert property (s_fed |=> !pump_boost)
        else $error("boost without low current");
    a_mode_reset: assert property (
        pump_boost |-> b_cnt < MODE_RESET_CYCLES + 4)
        else $error("boost outlived mode reset");
endmodule
bind lpm_mode_ctrl lpm_chk #(
    .SOFT_START_CYCLES(SOFT_START_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES),
    .MODE_RESET_CYCLES(MODE_RESET_CYCLES)
) u_chk (
    .pclk, .presetn, .group_a_enable, .group_b_enable, .low_current,
    .led_present, .pump_on, .pump_boost, .chip_enable, .led_current_on,
    .group_a_drive, .group_b_drive, .group_a_step, .group_b_step,
    .conn_error
);

/* lpm_host.sv */
// Host model that drives the two group enable pins.
// Assumes the bench calls its tasks right after a pclk edge.
`timescale 1ns/10ps
module lpm_host (
    input  wire logic pclk,
    output logic      group_a_enable,
    output logic      group_b_enable
);
    // Pins stay 3 us or more each way; random slack on top
    localparam int MIN_W = 120;
    initial begin
        group_a_enable = 1'b0;
        group_b_enable = 1'b0;
    end
    task automatic level(input int g, input logic v);
        @(posedge pclk);
        if (g == 0) begin
            group_a_enable <= v;
        end else begin
            group_b_enable <= v;
        end
    endtask
    // Low then high, so n pulses give n rising edges
    task automatic pulses(input int g, input int n);
        for (int i = 0; i < n; i++) begin
            level(g, 1'b0);
            repeat (MIN_W + $urandom_range(15)) @(posedge pclk);
            level(g, 1'b1);
            repeat (MIN_W + $urandom_range(15)) @(posedge pclk);
        end
    endtask
endmodule

/* tb_top.sv */
// Self-checking bench of the LED pump mode controller.
// Assumes lpm_host drives the enables; long counts are shortened.
`timescale 1ns/10ps
`include "lpm_params.svh"
`define CHK(g, e, m) check((g) === (e), m)
module tb_top;
    // Hold exceeds the widest host pulse so dimming never sleeps
    localparam int SOFT = 6000;
    localparam int HOLD = 200;
    localparam int MRST = 8000;
    localparam int POR  = 2000;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, group_a_enable, group_b_enable;
    logic        pump_on, pump_boost, chip_enable, led_current_on;
    logic        group_a_drive, group_b_drive, conn_error;
    logic [3:0]  group_a_step, group_b_step;
    logic [5:0]  low_current = 6'h00, led_present = 6'h3F;
    int          n_tests = 0, n_mismatch = 0, cycles = 0, n, exp_a;
    lpm_mode_ctrl #(
        .SOFT_START_CYCLES(SOFT),
        .HOLD_CYCLES(HOLD),
        .MODE_RESET_CYCLES(MRST)
    ) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .group_a_enable, .group_b_enable,
        .low_current, .led_present, .pump_on, .pump_boost, .chip_enable,
        .led_current_on, .group_a_drive, .group_b_drive, .group_a_step,
        .group_b_step, .conn_error
    );
    lpm_host host (.pclk, .group_a_enable, .group_b_enable);
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end
    task automatic conclude;
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    initial begin
        void'($urandom(94));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (POR - 100) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(q[4:0], 5'h00, "por status");
        repeat (200) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(q[5:0], 6'h04, "save status");
        $display("Test power-on done");
        host.level(0, 1'b1);
        wait_for(pump_on, 1'b1, 8);
        `CHK({pump_boost, chip_enable, group_a_step}, 6'h31, "start");
        host.pulses(0, 4);
        exp_a = 5;
        `CHK({led_current_on, group_a_step}, {1'b0, 4'(exp_a)}, "soft");
        wait_for(led_current_on, 1'b1, SOFT);
        `CHK({pump_boost, group_a_drive}, 2'b01, "led on");
        repeat (500) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        `CHK({q[11:8], q[5:0]}, {4'(exp_a), 6'h3D}, "run");
        $display("Test startup done");
        low_current <= 6'h01 << $urandom_range(5);
        wait_for(pump_boost, 1'b1, 12000);
        `CHK(pump_boost, 1'b1, "boost");
        wait_for(pump_boost, 1'b0, MRST + 10);
        `CHK(pump_boost, 1'b0, "mode reset");
        wait_for(pump_boost, 1'b1, MRST);
        `CHK(n >= 3399 && n < MRST, 1'b1, "hold");
        apb(1'b0, 12'h008, 32'h0);
        `CHK(q[15:0], 16'h0002, "upcount");
        host.level(0, 1'b0);
        low_current <= 6'h00;
        repeat (140) @(posedge pclk);
        `CHK({pump_on, pump_boost, chip_enable}, 3'b100, "ce low");
        host.level(0, 1'b1);
        exp_a = exp_a + 1;
        repeat (5) @(posedge pclk);
        `CHK({chip_enable, group_a_step}, {1'b1, 4'(exp_a)}, "ce");
        $display("Test mode switching done");
        host.level(0, 1'b0);
        repeat (HOLD + 20) @(posedge pclk);
        `CHK({pump_on, led_current_on, group_a_step}, 6'h00, "save");
        `CHK(conn_error, 1'b0, "conn quiet");
        // Channel 5 goes absent while asleep, so restart maps it out
        led_present <= 6'h1F;
        host.level(0, 1'b1);
        wait_for(led_current_on, 1'b1, SOFT + 10);
        `CHK(group_a_step, 4'h1, "restart");
        low_current <= 6'h20;
        repeat (MRST + 1000) @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0);
        `CHK({pump_boost, q[15:0]}, 17'h00002, "absent");
        low_current <= 6'h00;
        led_present <= 6'h3F;
        repeat (10) @(posedge pclk);
        `CHK(conn_error, 1'b1, "conn");
        led_present <= 6'h1F;
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(q[6], 1'b0, "clear");
        apb(1'b0, 12'h00C, 32'h0);
        `CHK({err, q}, {1'b1, 32'h0}, "unmapped");
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(q[1:0], 2'h1, "forced");
        $display("Test power-save and access done");
        host.level(1, 1'b1);
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (POR - 50) @(posedge pclk);
        `CHK(pump_on, 1'b0, "por wait");
        wait_for(pump_on, 1'b1, 100);
        `CHK({chip_enable, group_b_step}, 5'h11, "por start");
        $display("Test enable at power-up done");
        conclude();
    end
endmodule
